// File: hdl/half_bridge_input_decoder_defines.svh
// Constants for the half-bridge input decoder: mode codes, dead time.
// Assumes a 50 MHz system clock.
`ifndef HALF_BRIDGE_INPUT_DECODER_DEFINES_SVH
`define HALF_BRIDGE_INPUT_DECODER_DEFINES_SVH

`define MODE_SIX_INPUT 3'h0
`define MODE_THREE_INPUT 3'h1
`define MODE_SINGLE_PWM 3'h2
`define MODE_INDEP_HALF 3'h3
`define MODE_AB_HALF_C_FET 3'h4
`define MODE_BC_HALF_A_FET 3'h5
`define MODE_A_HALF_BC_FET 3'h6
`define MODE_INDEP_FET 3'h7

`define CLK_PERIOD_NS 20
`define DEAD_TIME_NS 100
// Least time, rounded up to whole cycles
`define DEAD_CYCLES ((`DEAD_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DEAD_CNT_W 4

`endif

// File: hdl/half_bridge_input_decoder_pkg.sv
// Types shared by the half-bridge input decoder files.
// Assumes the defines header is compiled alongside.
package half_bridge_input_decoder_pkg;
  typedef enum logic [2:0] {
    ph_off = 3'h1,
    ph_dead = 3'h2,
    ph_on = 3'h4
  } phase_state_t;
endpackage : half_bridge_input_decoder_pkg

// File: hdl/dead_time_phase.sv
// One half-bridge phase: gate requests to registered gate outputs.
// Requests are synchronous; bypass registers the requests onto the gates with no dead time.
`timescale 1ns/1ps
`default_nettype none
`include "half_bridge_input_decoder_defines.svh"

module dead_time_phase (
  input wire logic i_sys_clk, // System clock
  input wire logic i_rst_n, // Synchronised reset, active low
  input wire logic i_bypass, // Independent-FET phase
  input wire logic i_req_high, // Requested high gate
  input wire logic i_req_low, // Requested low gate
  output logic o_high_gate, // High gate drive
  output logic o_low_gate // Low gate drive
);
  half_bridge_input_decoder_pkg::phase_state_t state;
  logic [`DEAD_CNT_W-1:0] dead_cnt;
  logic want_high;
  logic want_low;

  // Both requested in a half-bridge is treated as both off
  assign want_high = i_req_high & ~i_req_low;
  assign want_low = i_req_low & ~i_req_high;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= half_bridge_input_decoder_pkg::ph_off;
      dead_cnt <= '0;
      o_high_gate <= 1'b0;
      o_low_gate <= 1'b0;
    end else if (i_bypass) begin
      o_high_gate <= i_req_high;
      o_low_gate <= i_req_low;
      state <= half_bridge_input_decoder_pkg::ph_off;
      dead_cnt <= '0;
    end else begin
      case (state)
        half_bridge_input_decoder_pkg::ph_off: begin
          o_high_gate <= 1'b0;
          o_low_gate <= 1'b0;
          if (want_high | want_low) begin
            state <= half_bridge_input_decoder_pkg::ph_dead;
            dead_cnt <= `DEAD_CNT_W'(`DEAD_CYCLES - 1);
          end
        end
        half_bridge_input_decoder_pkg::ph_dead: begin
          if (!(want_high | want_low)) begin
            state <= half_bridge_input_decoder_pkg::ph_off;
          end else if (dead_cnt == '0) begin
            state <= half_bridge_input_decoder_pkg::ph_on;
            o_high_gate <= want_high;
            o_low_gate <= want_low;
          end else begin
            dead_cnt <= dead_cnt - 1'b1;
          end
        end
        half_bridge_input_decoder_pkg::ph_on: begin
          // Any change first drops both gates
          if (want_high != o_high_gate || want_low != o_low_gate) begin
            o_high_gate <= 1'b0;
            o_low_gate <= 1'b0;
            state <= half_bridge_input_decoder_pkg::ph_off;
          end
        end
        default: begin
          state <= half_bridge_input_decoder_pkg::ph_off;
          o_high_gate <= 1'b0;
          o_low_gate <= 1'b0;
        end
      endcase
    end
  end
endmodule : dead_time_phase
`default_nettype wire

// File: hdl/half_bridge_input_decoder.sv
// Gate command decoder for three-input, single-PWM and mixed modes.
// Inputs synchronous to i_sys_clk; mode held stable while switching.
`timescale 1ns/1ps
`default_nettype none
`include "half_bridge_input_decoder_defines.svh"

module half_bridge_input_decoder (
  input wire logic i_sys_clk, // 50 MHz clock
  input wire logic i_arst_n, // Async reset, active low
  input wire logic [2:0] i_bridge_control_select, // Mode code
  input wire logic i_serial_variant, // 1: serial-configured part
  input wire logic i_rectification_select, // 1: diode freewheel
  input wire logic i_brake_coast_select, // 1: coast on brake
  input wire logic [2:0] i_high_in, // high_in_x, index 0 = A
  input wire logic [2:0] i_low_in, // low_in_x, index 0 = A
  output logic [2:0] o_high_gate, // high_gate_x, index 0 = A
  output logic [2:0] o_low_gate, // low_gate_x, index 0 = A
  output logic o_mode_supported // Mode decoded by this block
);
  logic rst_meta_n;
  logic rst_n;
  logic [2:0] mode;
  logic pwm_in_a;
  logic [2:0] state_abc;
  logic direction_in;
  logic brake_n;
  logic [2:0] fwd_code;
  logic [2:0] req_high;
  logic [2:0] req_low;
  logic [2:0] bypass;
  logic [2:0] gate_high;
  logic [2:0] gate_low;
  logic supported;
  logic [1:0] src;
  logic [1:0] snk;
  logic drive;

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_meta_n <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n <= rst_meta_n;
    end
  end

  assign mode = i_bridge_control_select;
  assign pwm_in_a = i_high_in[0];
  assign state_abc = {i_low_in[0], i_high_in[1], i_low_in[1]};
  assign direction_in = i_high_in[2];
  assign brake_n = i_low_in[2];
  assign fwd_code = direction_in ? ~state_abc : state_abc;

  // Source and sink phases of the six-step table
  always_comb begin
    src = 2'h0;
    snk = 2'h0;
    drive = 1'b1;
    case (fwd_code)
      3'h6: begin src = 2'h1; snk = 2'h2; end
      3'h4: begin src = 2'h0; snk = 2'h2; end
      3'h5: begin src = 2'h0; snk = 2'h1; end
      3'h1: begin src = 2'h2; snk = 2'h1; end
      3'h3: begin src = 2'h2; snk = 2'h0; end
      3'h2: begin src = 2'h1; snk = 2'h0; end
      default: drive = 1'b0;
    endcase
  end

  always_comb begin
    req_high = 3'h0;
    req_low = 3'h0;
    bypass = 3'h0;
    supported = 1'b1;
    case (mode)
      `MODE_THREE_INPUT, `MODE_INDEP_HALF: begin
        req_high = i_low_in & i_high_in;
        req_low = i_low_in & ~i_high_in;
      end
      `MODE_SINGLE_PWM: begin
        if (!brake_n) begin
          req_high = 3'h0;
          req_low = (i_serial_variant && i_brake_coast_select) ?
                    3'h0 : 3'h7;
        end else if (state_abc == 3'h7) begin
          req_high[0] = pwm_in_a;
          req_low = {2'h3, ~pwm_in_a &
                    ~(i_serial_variant & i_rectification_select)};
        end else if (drive) begin
          req_high[src] = pwm_in_a;
          req_low[src] = ~pwm_in_a &
                         ~(i_serial_variant & i_rectification_select);
          req_low[snk] = 1'b1;
        end
      end
      `MODE_AB_HALF_C_FET: begin
        if (i_serial_variant) begin
          req_high = {i_high_in[2], i_low_in[1:0] & i_high_in[1:0]};
          req_low = {i_low_in[2], i_low_in[1:0] & ~i_high_in[1:0]};
          bypass = 3'h4;
        end else begin
          supported = 1'b0;
        end
      end
      `MODE_BC_HALF_A_FET: begin
        req_high = {i_low_in[2:1] & i_high_in[2:1], i_high_in[0]};
        req_low = {i_low_in[2:1] & ~i_high_in[2:1], i_low_in[0]};
        bypass = 3'h1;
      end
      `MODE_A_HALF_BC_FET: begin
        req_high = {i_high_in[2:1], i_low_in[0] & i_high_in[0]};
        req_low = {i_low_in[2:1], i_low_in[0] & ~i_high_in[0]};
        bypass = 3'h6;
      end
      default: begin
        // left to the other decoders; gates off here
        supported = 1'b0;
      end
    endcase
  end

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : gen_phase
      dead_time_phase u_phase (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(rst_n),
        .i_bypass(bypass[g]),
        .i_req_high(req_high[g]),
        .i_req_low(req_low[g]),
        .o_high_gate(gate_high[g]),
        .o_low_gate(gate_low[g])
      );
    end
  endgenerate

  assign o_high_gate = gate_high;
  assign o_low_gate = gate_low;

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_mode_supported <= 1'b0;
    end else begin
      o_mode_supported <= supported;
    end
  end
endmodule : half_bridge_input_decoder
`default_nettype wire

// File: tb/half_bridge_input_decoder_checker.sv
// Checker for the half-bridge input decoder, bound to its top ports.
// Assumes inputs change off the rising edge of i_sys_clk.
`timescale 1ns/1ps
`default_nettype none
module half_bridge_input_decoder_checker (
  input wire logic i_sys_clk, // Clock
  input wire logic i_arst_n, // Async reset, active low
  input wire logic [2:0] i_bridge_control_select, // Mode
  input wire logic i_serial_variant, // Serial part
  input wire logic i_rectification_select, // Diode freewheel
  input wire logic i_brake_coast_select, // Coast on brake
  input wire logic [2:0] i_high_in, // High inputs
  input wire logic [2:0] i_low_in, // Low inputs
  input wire logic [2:0] o_high_gate, // High gates
  input wire logic [2:0] o_low_gate, // Low gates
  input wire logic o_mode_supported // Mode flag
);
  logic [2:0] m;
  assign m = i_bridge_control_select;
  default clocking @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_arst_n);
  shoot_guard_a: assert property (
    m inside {3'h1, 3'h2, 3'h3} |-> (o_high_gate & o_low_gate) == 3'h0)
    else $error("half-bridge with both gates on");
  dead_gap_a: assert property (
    $fell(o_low_gate[0]) && m != 3'h5 |-> (!o_high_gate[0]) [*6])
    else $error("phase A high gate on inside dead time");
  lo_gap_a: assert property (
    $fell(o_high_gate[1]) && m != 3'h6 |-> (!o_low_gate[1]) [*6])
    else $error("phase B low gate on inside dead time");
  refuse_off_a: assert property (
    (m == 3'h0 || m == 3'h7) [*2] |=>
    o_high_gate == 3'h0 && o_low_gate == 3'h0 && !o_mode_supported)
    else $error("unsupported mode drives gates");
  strap_refuse_a: assert property (
    m == 3'h4 && !i_serial_variant |=> !o_mode_supported)
    else $error("mode 4 accepted on strapped part");
  brake_lows_a: assert property (
    (m == 3'h2 && !i_low_in[2]
      && !(i_serial_variant && i_brake_coast_select)) [*8]
    |-> o_high_gate == 3'h0 && o_low_gate == 3'h7)
    else $error("brake does not hold all low gates");
  fet_follow_a: assert property (
    m == 3'h5 && $past(m) == 3'h5 |=>
    o_high_gate[0] == $past(i_high_in[0])
    && o_low_gate[0] == $past(i_low_in[0]))
    else $error("phase A FET gates not direct");
  hiz_off_a: assert property (
    (m == 3'h1 && !i_low_in[1]) [*2] |=> !o_high_gate[1] && !o_low_gate[1])
    else $error("phase B not off with low input low");
  level_follow_a: assert property (
    (m == 3'h1 && i_low_in[0] && i_high_in[0]) [*8]
    |-> o_high_gate[0] && !o_low_gate[0])
    else $error("phase A not high");
endmodule : half_bridge_input_decoder_checker
`default_nettype wire

// File: tb/pin_controller_model.sv
// Controller model: puts levels or packed single-PWM fields on the pins.
// Assumes the bench idles the pins before any mode change.
`timescale 1ns/1ps
`default_nettype none
module pin_controller_model (
  input wire logic i_one_pwm, // Pack pwm, state, direction, brake
  input wire logic [5:0] i_pins, // {high,low} or packed fields
  output logic [2:0] o_high_in, // high_in_x
  output logic [2:0] o_low_in // low_in_x
);
  // pwm on A, state, direction, brake
  // rows keep unused low inputs high
  always_comb begin
    if (i_one_pwm) begin
      o_high_in = {i_pins[1], i_pins[3], i_pins[5]};
      o_low_in = {i_pins[0], i_pins[2], i_pins[4]};
    end else begin
      o_high_in = i_pins[5:3];
      o_low_in = i_pins[2:0];
    end
  end
endmodule : pin_controller_model
`default_nettype wire

// File: tb/half_bridge_input_decoder_bench.sv
// Self-checking bench for the half-bridge input decoder.
// Assumes gates settle within 7 edges of a request.
`timescale 1ns/1ps
`default_nettype none
module half_bridge_input_decoder_bench;
  logic clk, arst_n, sup;
  logic [2:0] sel, flags, hi, lo, gh, gl;
  logic [5:0] pins;
  logic ms;
  int err_total = 0;
  int checks_done = 0;
  // Nibbles: mode, {serial,rect,coast}, pins hi, pins lo, high, low
  logic [23:0] rows [33] = '{24'h105752, 24'h107550, 24'h302321,
    24'h447444, 24'h407400, 24'h501717, 24'h607776, 24'h007700,
    24'h707700, 24'h207124, 24'h203106, 24'h263104, 24'h206114,
    24'h206512, 24'h204542, 24'h205541, 24'h205121, 24'h204724,
    24'h205714, 24'h205312, 24'h207342, 24'h206341, 24'h206721,
    24'h204300, 24'h207716, 24'h207007, 24'h217007, 24'h257000,
    24'h247007, 24'h204100, 24'h207516, 24'h203707, 24'h263706};
  half_bridge_input_decoder dut (.i_sys_clk(clk), .i_arst_n(arst_n),
    .i_bridge_control_select(sel), .i_serial_variant(flags[2]),
    .i_rectification_select(flags[1]), .i_brake_coast_select(flags[0]),
    .i_high_in(hi), .i_low_in(lo), .o_high_gate(gh), .o_low_gate(gl),
    .o_mode_supported(ms));
  pin_controller_model ctrl (.i_one_pwm(sel == 3'h2), .i_pins(pins),
    .o_high_in(hi), .o_low_in(lo));
  task automatic check(input string nm, input logic [2:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  task automatic results;
    if (err_total == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    #100000;
    err_total++;
    results();
  end
  initial begin
    arst_n = 1'b0;
    sel = 3'h0;
    flags = 3'h0;
    pins = 6'h00;
    cyc(12);
    check("reset high", gh, 3'h0);
    check("reset low", gl, 3'h0);
    arst_n = 1'b1;
    cyc(4);
    foreach (rows[i]) begin
      pins = 6'h00;
      cyc(8);
      sel = rows[i][22:20];
      flags = rows[i][18:16];
      cyc(2);
      pins = {rows[i][14:12], rows[i][10:8]};
      cyc(12);
      sup = sel != 3'h0 && sel != 3'h7 && (sel != 3'h4 || flags[2]);
      check("high gates", gh, rows[i][6:4]);
      check("low gates", gl, rows[i][2:0]);
      check("supported", {2'h0, ms}, {2'h0, sup});
    end
    pins = 6'h00;
    cyc(8);
    sel = 3'h1;
    flags = 3'h0;
    pins = 6'h07;
    cyc(12);
    pins = 6'h0f;
    cyc(1);
    check("dead low", gl, 3'h6);
    cyc(5);
    check("dead high", gh, 3'h0);
    cyc(1);
    check("new high", gh, 3'h1);
    pins = 6'h00;
    cyc(8);
    sel = 3'h5;
    cyc(2);
    pins = 6'h09;
    cyc(1);
    check("fet high", gh, 3'h1);
    check("fet low", gl, 3'h1);
    arst_n = 1'b0;
    #1;
    check("mid reset high", gh, 3'h0);
    check("mid reset low", gl, 3'h0);
    sel = 3'h0;
    pins = 6'h00;
    cyc(3);
    arst_n = 1'b1;
    cyc(4);
    check("after reset high", gh, 3'h0);
    check("after reset low", gl, 3'h0);
    check("after reset mode", {2'h0, ms}, 3'h0);
    results();
  end
endmodule : half_bridge_input_decoder_bench
bind half_bridge_input_decoder half_bridge_input_decoder_checker chk (
  .i_sys_clk, .i_arst_n, .i_bridge_control_select, .i_serial_variant,
  .i_rectification_select, .i_brake_coast_select, .i_high_in, .i_low_in,
  .o_high_gate, .o_low_gate, .o_mode_supported);
`default_nettype wire
